// ---- design/srcc_pkg.sv ----
package srcc_pkg;

  // Byte offsets of the word registers
  localparam logic [11:0] CMD_OFFSET     = 12'h1b4;
  localparam logic [11:0] DATA_OFFSET    = 12'h1b8;
  localparam logic [11:0] HWCFG_OFFSET   = 12'h074;
  localparam logic [11:0] IRQ_STS_OFFSET = 12'h1c0;
  localparam logic [11:0] IRQ_EN_OFFSET  = 12'h1c4;
  localparam logic [11:0] IRQ_CLR_OFFSET = 12'h1c8;

  // Field positions
  localparam int BUSY_BIT    = 31;
  localparam int OP_HI       = 30;
  localparam int OP_LO       = 28;
  localparam int OVF_BIT     = 18;
  localparam int TIMEOUT_BIT = 17;
  localparam int SOFTRST_BIT = 0;
  localparam int DRST_BIT    = 1;
  localparam int LOADED_BIT  = 2;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int FRAME_W = 3 + ADDR_W + DATA_W;
  localparam int IRQ_W   = 3;

  // Interrupt status bits
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_LOADED  = 2;

  // Link frame encodings
  localparam logic [1:0]        LINK_OC_READ  = 2'h2;
  localparam logic [1:0]        LINK_OC_WRITE = 2'h1;
  localparam logic [1:0]        LINK_OC_ERASE = 2'h3;
  localparam logic [1:0]        LINK_OC_SPEC  = 2'h0;
  localparam logic [ADDR_W-1:0] LINK_A_EWDIS  = 8'h00;
  localparam logic [ADDR_W-1:0] LINK_A_EWON   = 8'hc0;
  localparam logic [ADDR_W-1:0] LINK_A_WRALL  = 8'h40;
  localparam logic [ADDR_W-1:0] LINK_A_ERALL  = 8'h80;

  // Loader image markers
  localparam logic [7:0]        LOAD_SIGNATURE  = 8'ha5;
  localparam logic [DATA_W-1:0] LOAD_TERMINATOR = 16'hffff;
  localparam logic [ADDR_W-1:0] LOAD_CFG_ADDR   = 8'h01;
  localparam logic [ADDR_W-1:0] LOAD_LAST_ADDR  = 8'hff;

  // Timing
  localparam int TIMEOUT_MS          = 30;
  localparam int CLK_HZ              = 125000000;
  localparam int TIMEOUT_CYCLES_DFLT = TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    OP_READ                    = 3'h0,
    OP_ERASE_WRITE_DISABLE_CMD = 3'h1,
    OP_ERASE_WRITE_ENABLE_CMD  = 3'h2,
    OP_WRITE                   = 3'h3,
    OP_WRITE_ALL_CMD           = 3'h4,
    OP_ERASE                   = 3'h5,
    OP_ERASE_ALL_CMD           = 3'h6,
    OP_RELOAD                  = 3'h7
  } srcc_op_t;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_SHIFT    = 5'h02,
    ST_GAP      = 5'h04,
    ST_WAIT_RDY = 5'h08,
    ST_DONE     = 5'h10
  } srcc_fsm_t;

  typedef struct packed {
    srcc_fsm_t          fsm;
    logic               controller_busy_flag;
    srcc_op_t           operation_select_field;
    srcc_op_t           cur_op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
    logic               operation_timeout_flag;
    logic               overflow;
    logic               loaded;
    logic               loader;
    logic               sig_ok;
    logic               kick;
    logic [ADDR_W-1:0]  ld_addr;
    logic [DATA_W-1:0]  cfg_word;
    logic [FRAME_W-1:0] shreg;
    logic [4:0]         bitcnt;
    logic [31:0]        tocnt;
    logic [2:0]         clk_sync;
    logic [1:0]         di_sync;
    logic               cs;
    logic               dout;
    logic [IRQ_W-1:0]   irq_sts;
    logic [IRQ_W-1:0]   irq_en;
    logic               ph_valid;
    logic               ph_write;
    logic [11:0]        ph_addr;
    logic [31:0]        hrdata;
  } srcc_state_t;

endpackage

// ---- design/srcc_top.sv ----
// Functional notes
// RULE1: Writing one to bit 31 of the command register starts the selected operation at the programmed address.
// RULE2: The busy bit stays set for the whole operation and hardware clears it only when the operation ends.
// RULE3: For a read, busy clearing means the data register holds the word fetched from the memory.
// RULE4: Software should not touch command or data registers while busy reads one, nor issue overlapping commands.
// RULE5: A write with no memory attached keeps busy set until the timeout flag sets, then busy clears.
// RULE6: Busy is forced to one right after power-up, pin reset and digital reset.
// RULE7: Busy is also set when software sets the soft reset bit of the hardware config register.
// RULE8: After any reset-started busy period, busy clears once the configuration loader has finished reading.
// RULE9: The operation coded in bits 30:28, reset value 000, is executed only when busy is set.
// RULE10: Codes: 0 read, 1 erase/write disable, 2 erase/write enable, 3 write, 4 write all, 5 erase, 6 erase all, 7 reload.
// RULE11: Erase, erase all, write or write all with no answer within 30 ms sets the timeout flag and returns to idle.
// RULE12: The loader overflow flag clears whenever the loader restarts by reload, soft reset or digital reset.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps

module srcc_top #(
  parameter int TIMEOUT_CYCLES = srcc_pkg::TIMEOUT_CYCLES_DFLT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rom_link_clk,
  input  wire logic        rom_di,
  output logic             rom_cs,
  output logic             rom_do,
  output logic      [15:0] cfg_word,
  output logic             irq
);

  // Ready wait needs at least one counted cycle before the limit
  if (TIMEOUT_CYCLES < 2)
  begin : g_timeout_check
    $error("TIMEOUT_CYCLES must be at least 2");
  end

  localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CYCLES - 1);
  localparam logic [4:0]  FRAME_BITS = 5'(srcc_pkg::FRAME_W);

  srcc_pkg::srcc_state_t s;
  srcc_pkg::srcc_state_t next_s;

  function automatic logic [srcc_pkg::FRAME_W-1:0] build_frame(
    input srcc_pkg::srcc_op_t         op,
    input logic [srcc_pkg::ADDR_W-1:0] a,
    input logic [srcc_pkg::DATA_W-1:0] d
  );
    logic [1:0]                  oc;
    logic [srcc_pkg::ADDR_W-1:0] fa;
    logic [srcc_pkg::DATA_W-1:0] fd;
    oc = srcc_pkg::LINK_OC_SPEC;
    fa = a;
    fd = d;
    unique case (op)
      srcc_pkg::OP_READ, srcc_pkg::OP_RELOAD:
      begin
        oc = srcc_pkg::LINK_OC_READ;
        fd = '0;
      end
      srcc_pkg::OP_WRITE:                   oc = srcc_pkg::LINK_OC_WRITE;
      srcc_pkg::OP_ERASE:                   oc = srcc_pkg::LINK_OC_ERASE;
      srcc_pkg::OP_ERASE_WRITE_DISABLE_CMD: fa = srcc_pkg::LINK_A_EWDIS;
      srcc_pkg::OP_ERASE_WRITE_ENABLE_CMD:  fa = srcc_pkg::LINK_A_EWON;
      srcc_pkg::OP_WRITE_ALL_CMD:           fa = srcc_pkg::LINK_A_WRALL;
      srcc_pkg::OP_ERASE_ALL_CMD:           fa = srcc_pkg::LINK_A_ERALL;
    endcase
    return {1'b1, oc, fa, fd};
  endfunction

  function automatic logic needs_ready(input srcc_pkg::srcc_op_t op);
    return (op == srcc_pkg::OP_WRITE) || (op == srcc_pkg::OP_WRITE_ALL_CMD) ||
           (op == srcc_pkg::OP_ERASE) || (op == srcc_pkg::OP_ERASE_ALL_CMD);
  endfunction

  logic        addr_phase;
  logic        link_rise;
  logic        di;
  logic [31:0] wd;
  logic        restart;
  logic [31:0] rd_mux;

  assign addr_phase = hsel && htrans[1] && hready;
  assign link_rise  = s.clk_sync[1] && !s.clk_sync[2];
  assign di         = s.di_sync[1];
  assign wd         = hwdata;

  always_comb
  begin
    next_s = s;
    restart = 1'b0;

    // Pin synchronisers; stage 0 feeds only stage 1
    next_s.clk_sync = {s.clk_sync[1:0], rom_link_clk};
    next_s.di_sync  = {s.di_sync[0], rom_di};

    // Read data is fetched in the address phase so it stands in the data phase
    rd_mux = 32'h0000_0000;
    unique case (haddr[11:0])
      srcc_pkg::CMD_OFFSET:
      begin
        rd_mux[srcc_pkg::BUSY_BIT]             = s.controller_busy_flag;
        rd_mux[srcc_pkg::OP_HI:srcc_pkg::OP_LO] = s.operation_select_field;
        rd_mux[srcc_pkg::OVF_BIT]              = s.overflow;
        rd_mux[srcc_pkg::TIMEOUT_BIT]          = s.operation_timeout_flag;
        rd_mux[srcc_pkg::ADDR_W-1:0]           = s.addr;
      end
      srcc_pkg::DATA_OFFSET:    rd_mux[srcc_pkg::DATA_W-1:0] = s.data;
      srcc_pkg::HWCFG_OFFSET:   rd_mux[srcc_pkg::LOADED_BIT] = s.loaded;
      srcc_pkg::IRQ_STS_OFFSET: rd_mux[srcc_pkg::IRQ_W-1:0] = s.irq_sts;
      srcc_pkg::IRQ_EN_OFFSET:  rd_mux[srcc_pkg::IRQ_W-1:0] = s.irq_en;
      default:                  rd_mux = 32'h0000_0000;
    endcase

    next_s.ph_valid = addr_phase;
    if (addr_phase)
    begin
      next_s.ph_write = hwrite;
      next_s.ph_addr  = haddr[11:0];
      if (!hwrite)
        next_s.hrdata = rd_mux;
    end

    // Data phase of a write; engine events below override, so a set beats a clear
    if (s.ph_valid && s.ph_write)
    begin
      unique case (s.ph_addr)
        srcc_pkg::CMD_OFFSET:
        begin
          if (wd[srcc_pkg::TIMEOUT_BIT])
            next_s.operation_timeout_flag = 1'b0;
          // Fields are frozen while busy; writes then only clear the timeout
          if (!s.controller_busy_flag)                                            // [RULE4]
          begin
            next_s.operation_select_field = srcc_pkg::srcc_op_t'(wd[srcc_pkg::OP_HI:srcc_pkg::OP_LO]);
            next_s.addr = wd[srcc_pkg::ADDR_W-1:0];
            if (wd[srcc_pkg::BUSY_BIT])
            begin
              next_s.controller_busy_flag = 1'b1;                                 // [RULE1]
              if (srcc_pkg::srcc_op_t'(wd[srcc_pkg::OP_HI:srcc_pkg::OP_LO]) == srcc_pkg::OP_RELOAD)
                restart = 1'b1;                                                   // [RULE10]
              else
              begin
                next_s.cur_op = srcc_pkg::srcc_op_t'(wd[srcc_pkg::OP_HI:srcc_pkg::OP_LO]); // [RULE9]
                next_s.kick = 1'b1;
              end
            end
          end
        end
        srcc_pkg::DATA_OFFSET:
        begin
          if (!s.controller_busy_flag)
            next_s.data = wd[srcc_pkg::DATA_W-1:0];
        end
        srcc_pkg::HWCFG_OFFSET:
        begin
          if (wd[srcc_pkg::SOFTRST_BIT] || wd[srcc_pkg::DRST_BIT])
            restart = 1'b1;                                                       // [RULE7]
        end
        srcc_pkg::IRQ_EN_OFFSET:  next_s.irq_en = wd[srcc_pkg::IRQ_W-1:0];
        srcc_pkg::IRQ_CLR_OFFSET: next_s.irq_sts = s.irq_sts & ~wd[srcc_pkg::IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end

    // Serial engine
    unique case (s.fsm)
      srcc_pkg::ST_IDLE:
      begin
        if (s.kick && s.controller_busy_flag)                                     // [RULE9]
        begin
          next_s.kick   = 1'b0;
          next_s.shreg  = build_frame(s.cur_op, s.loader ? s.ld_addr : s.addr, s.data); // [RULE10]
          next_s.bitcnt = FRAME_BITS;
          next_s.fsm    = srcc_pkg::ST_SHIFT;
        end
      end
      srcc_pkg::ST_SHIFT:
      begin
        if (link_rise)
        begin
          next_s.cs     = 1'b1;
          next_s.dout   = s.shreg[srcc_pkg::FRAME_W-1];
          next_s.shreg  = {s.shreg[srcc_pkg::FRAME_W-2:0], di};
          next_s.bitcnt = s.bitcnt - 5'h01;
          if (s.bitcnt == 5'h01)
            next_s.fsm = srcc_pkg::ST_GAP;
        end
      end
      srcc_pkg::ST_GAP:
      begin
        if (link_rise)
        begin
          next_s.cs    = 1'b0;
          next_s.dout  = 1'b0;
          next_s.tocnt = 32'h0000_0000;
          next_s.fsm   = needs_ready(s.cur_op) ? srcc_pkg::ST_WAIT_RDY : srcc_pkg::ST_DONE;
        end
      end
      srcc_pkg::ST_WAIT_RDY:
      begin
        if (link_rise)
          next_s.cs = 1'b1;
        next_s.tocnt = s.tocnt + 32'h0000_0001;
        if (s.cs && di)
        begin
          next_s.cs  = 1'b0;
          next_s.fsm = srcc_pkg::ST_DONE;
        end
        else if (s.tocnt == TO_LAST)
        begin
          // Missing memory ends here: flag set and busy released together
          next_s.cs = 1'b0;
          next_s.operation_timeout_flag = 1'b1;                                   // [RULE11] [RULE5]
          next_s.irq_sts[srcc_pkg::IRQ_TIMEOUT] = 1'b1;
          next_s.controller_busy_flag = 1'b0;                                     // [RULE5]
          next_s.irq_sts[srcc_pkg::IRQ_OP_DONE] = 1'b1;
          next_s.fsm = srcc_pkg::ST_IDLE;
        end
      end
      srcc_pkg::ST_DONE:
      begin
        next_s.fsm = srcc_pkg::ST_IDLE;
        if (!s.loader)
        begin
          if (s.cur_op == srcc_pkg::OP_READ)
            next_s.data = s.shreg[srcc_pkg::DATA_W-1:0];                          // [RULE3]
          next_s.controller_busy_flag = 1'b0;                                     // [RULE2]
          next_s.irq_sts[srcc_pkg::IRQ_OP_DONE] = 1'b1;
        end
        else if (s.ld_addr == '0 && s.shreg[7:0] != srcc_pkg::LOAD_SIGNATURE)
        begin
          // Blank memory: loader gives up without loading
          next_s.loader = 1'b0;
          next_s.controller_busy_flag = 1'b0;                                     // [RULE8]
          next_s.irq_sts[srcc_pkg::IRQ_LOADED] = 1'b1;
        end
        else if (s.ld_addr != '0 && s.shreg[srcc_pkg::DATA_W-1:0] == srcc_pkg::LOAD_TERMINATOR)
        begin
          next_s.loader = 1'b0;
          next_s.loaded = 1'b1;
          next_s.controller_busy_flag = 1'b0;                                     // [RULE8]
          next_s.irq_sts[srcc_pkg::IRQ_LOADED] = 1'b1;
        end
        else if (s.ld_addr == srcc_pkg::LOAD_LAST_ADDR)
        begin
          next_s.overflow = 1'b1;
          next_s.loader = 1'b0;
          next_s.controller_busy_flag = 1'b0;                                     // [RULE8]
          next_s.irq_sts[srcc_pkg::IRQ_LOADED] = 1'b1;
        end
        else
        begin
          if (s.ld_addr == srcc_pkg::LOAD_CFG_ADDR)
            next_s.cfg_word = s.shreg[srcc_pkg::DATA_W-1:0];
          next_s.ld_addr = s.ld_addr + 8'h01;
          next_s.kick = 1'b1;
        end
      end
      default:
        next_s.fsm = srcc_pkg::ST_IDLE;
    endcase

    // Loader restart aborts any frame in flight
    if (restart)
    begin
      next_s.controller_busy_flag = 1'b1;                                         // [RULE7] [RULE6]
      next_s.overflow = 1'b0;                                                     // [RULE12]
      next_s.loaded   = 1'b0;
      next_s.loader   = 1'b1;
      next_s.ld_addr  = '0;
      next_s.cur_op   = srcc_pkg::OP_READ;
      next_s.kick     = 1'b1;
      next_s.cs       = 1'b0;
      next_s.dout     = 1'b0;
      next_s.fsm      = srcc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.fsm <= srcc_pkg::ST_IDLE;
      s.controller_busy_flag <= 1'b1;                                             // [RULE6]
      s.operation_select_field <= srcc_pkg::OP_READ;
      s.cur_op <= srcc_pkg::OP_READ;
      s.loader <= 1'b1;                                                           // [RULE8]
      s.kick <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hrdata    = s.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rom_cs    = s.cs;
  assign rom_do    = s.dout;
  assign cfg_word  = s.cfg_word;
  assign irq       = |(s.irq_sts & s.irq_en);

endmodule

// ---- dv/srcc_assertions.sv ----
`timescale 1ns/10ps
module srcc_assertions #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rom_link_clk,
  input wire logic        rom_cs,
  input wire logic        rom_do,
  input wire logic [15:0] cfg_word,
  input wire logic        irq
);
  // Frame length plus the longest ready wait, with slack for sync jitter
  localparam int CS_MAX = 480 + TIMEOUT_CYCLES;
  int cs_len;
  int cs_idle;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cs_len  <= 0;
      cs_idle <= 0;
    end
    else
    begin
      cs_len  <= rom_cs ? cs_len + 1 : 0;
      cs_idle <= rom_cs ? 0 : cs_idle + 1;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait OKAY");
  property p_rst_outs; $rose(hresetn) |-> !rom_cs && !rom_do && !irq && cfg_word == 16'h0; endproperty
  a_rst_outs: assert property (p_rst_outs) else $error("outputs not quiet after reset");
  property p_cs_rise; $rose(rom_cs) |-> rom_link_clk; endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("select rose away from a link rise");
  property p_do_on_clk; rom_cs && $changed(rom_do) |-> rom_link_clk; endproperty
  a_do_on_clk: assert property (p_do_on_clk) else $error("serial out moved off a link rise");
  property p_cs_gap; $fell(rom_cs) |-> !rom_cs [*6]; endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select reasserted too soon");
  property p_cs_bound; cs_len < CS_MAX; endproperty
  a_cs_bound: assert property (p_cs_bound) else $error("select held past the timeout");
  property p_cfg_load; $changed(cfg_word) |-> cs_idle < 40; endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config word changed outside a load");
  property p_rdata; $changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  property p_irq_fall; $fell(irq) |-> $past(hsel && htrans[1] && hwrite && hready, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a bus write");
  c_frame: cover property ($rose(rom_cs));
  c_irq: cover property ($rose(irq));
  c_cfg: cover property ($changed(cfg_word));
endmodule

// ---- dv/srcc_rom_model.sv ----
`timescale 1ns/10ps
module srcc_rom_model #(
  parameter logic [15:0] CFG = 16'h1234
) (
  input  wire logic rom_link_clk,
  input  wire logic rom_cs,
  input  wire logic rom_do,
  input  wire logic present,
  input  wire logic slow,
  output logic      rom_di
);
  logic [15:0] mem [256];
  logic [26:0] fr = '0;
  logic [7:0]  a = '0;
  logic [1:0]  op = '0;
  logic        wr_ok = 1'b0;
  logic        rdy_ph = 1'b0;
  logic        dbit = 1'b0;
  int          cnt = 0;
  int          dly = 0;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h3c00 | 16'(i);
    mem[0] = 16'h00a5;
    mem[1] = CFG;
    mem[2] = 16'hffff;
  end
  // Output bits are taken on the falling edge, mid-bit, where they are settled
  always @(negedge rom_link_clk)
    if (rdy_ph && dly > 0)
      dly--;
    else if (rom_cs && cnt < 27)
    begin
      fr = {fr[25:0], rom_do};
      cnt++;
      if (cnt == 11)
        {op, a} = fr[9:0];
      dbit = (cnt >= 11 && cnt < 27 && op == 2'h2) ? mem[a][26-cnt] : 1'b0;
      if (cnt == 27)
        casez ({op, a})
          10'b01????????: if (wr_ok) mem[a] = fr[15:0];
          10'b11????????: if (wr_ok) mem[a] = 16'hffff;
          10'h0c0: wr_ok = 1'b1;
          10'h000: wr_ok = 1'b0;
          10'h040: if (wr_ok) foreach (mem[i]) mem[i] = fr[15:0];
          10'h080: if (wr_ok) foreach (mem[i]) mem[i] = 16'hffff;
          default: ;
        endcase
    end
  // Only program and erase frames are followed by a ready poll
  always @(negedge rom_cs)
    if (rdy_ph || cnt < 27 || !(op[0] || (op == 2'h0 && a[7] != a[6])))
    begin
      rdy_ph = 1'b0;
      cnt = 0;
      dbit = 1'b0;
    end
    else
    begin
      rdy_ph = 1'b1;
      dly = slow ? 4 : 0;
    end
  // Pulled low whenever the part is absent or not selected
  assign rom_di = rom_cs && present && (rdy_ph ? dly == 0 : dbit);
endmodule

// ---- dv/tb_serial_rom_command_control.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_serial_rom_command_control;
  localparam logic [15:0] CFG = 16'h1234;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rom_link_clk;
  logic        rom_di;
  logic        rom_cs;
  logic        rom_do;
  logic [15:0] cfg_word;
  logic        irq;
  logic        present = 1'b1;
  logic        slow = 1'b0;
  logic        link_en = 1'b1;
  logic [31:0] rd;
  logic [31:0] seed = 32'hd3f6;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  srcc_top #(.TIMEOUT_CYCLES(200)) i_srcc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rom_link_clk(rom_link_clk), .rom_di(rom_di), .rom_cs(rom_cs), .rom_do(rom_do),
    .cfg_word(cfg_word), .irq(irq));
  srcc_rom_model #(.CFG(CFG)) i_srcc_rom_model (
    .rom_link_clk(rom_link_clk), .rom_cs(rom_cs), .rom_do(rom_do), .present(present), .slow(slow),
    .rom_di(rom_di));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Link clock runs only while link_en is set: during operations, loads and the no-frame check
  initial
  begin
    rom_link_clk = 1'b0;
    forever #62.5 rom_link_clk = link_en & ~rom_link_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
      n++;
    end
    while (rd[31] !== 1'b0 && n < 3000);
    `CHK("busy clears", 1'b0, rd[31])
    link_en = 1'b0;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [7:0] a, input logic [15:0] d);
    link_en = 1'b1;
    xfer(1'b1, srcc_pkg::DATA_OFFSET, {16'h0, d});
    xfer(1'b1, srcc_pkg::CMD_OFFSET, {1'b1, op, 20'h0, a});
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("busy set", 1'b1, rd[31])
    wait_idle();
    `CHK("irq raised", 1'b1, irq)
    xfer(1'b1, srcc_pkg::IRQ_CLR_OFFSET, 32'h7);
    @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    run_op(3'h0, a, 16'h0);
    xfer(1'b0, srcc_pkg::DATA_OFFSET, 32'h0);
    `CHK("read data", e, rd[15:0])
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("busy at reset", 1'b1, rd[31])
    `CHK("op at reset", 3'h0, rd[30:28])
    wait_idle();
    `CHK("loaded word", CFG, cfg_word)
    xfer(1'b0, srcc_pkg::HWCFG_OFFSET, 32'h0);
    `CHK("cfg loaded", 1'b1, rd[2])
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, srcc_pkg::IRQ_EN_OFFSET, 32'h7);
    @(posedge hclk);
    `CHK("irq loader", 1'b1, irq)
    xfer(1'b1, srcc_pkg::IRQ_CLR_OFFSET, 32'h7);
    xfer(1'b1, srcc_pkg::CMD_OFFSET, 32'h3000_0055);
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("op kept idle", 32'h3000_0055, rd)
    // Let the link run so a wrongly started frame would show
    link_en = 1'b1;
    repeat (40) @(posedge hclk);
    `CHK("no frame", 1'b0, rom_cs)
    link_en = 1'b0;
    $display("test reset and registers done");
    run_op(3'h2, 8'h0, 16'h0);
    repeat (3)
    begin
      seed = xs(seed);
      slow = seed[31];
      run_op(3'h3, seed[7:0], seed[23:8]);
      rd_chk(seed[7:0], seed[23:8]);
    end
    $display("test random write and read done");
    run_op(3'h5, seed[7:0], 16'h0);
    rd_chk(seed[7:0], 16'hffff);
    run_op(3'h1, 8'h0, 16'h0);
    run_op(3'h3, seed[7:0], 16'h1357);
    rd_chk(seed[7:0], 16'hffff);
    run_op(3'h2, 8'h0, 16'h0);
    run_op(3'h4, 8'h0, seed[15:0]);
    rd_chk(8'h77, seed[15:0]);
    run_op(3'h6, 8'h0, 16'h0);
    rd_chk(8'h77, 16'hffff);
    run_op(3'h7, 8'h0, 16'h0);
    xfer(1'b0, srcc_pkg::HWCFG_OFFSET, 32'h0);
    `CHK("reload blank", 1'b0, rd[2])
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("overflow clear", 1'b0, rd[18])
    $display("test operation codes done");
    present = 1'b0;
    run_op(3'h3, 8'h12, 16'h0);
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("timeout flag", 1'b1, rd[17])
    xfer(1'b1, srcc_pkg::CMD_OFFSET, 32'h0002_0000);
    xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
    `CHK("timeout cleared", 1'b0, rd[17])
    present = 1'b1;
    $display("test timeout done");
    for (int b = 0; b < 2; b++)
    begin
      link_en = 1'b1;
      xfer(1'b1, srcc_pkg::HWCFG_OFFSET, 32'h1 << b);
      xfer(1'b0, srcc_pkg::CMD_OFFSET, 32'h0);
      `CHK("busy on restart", 1'b1, rd[31])
      wait_idle();
    end
    $display("test restarts done");
    print_verdict();
  end
endmodule
bind srcc_top srcc_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_srcc_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rom_link_clk(rom_link_clk),
  .rom_cs(rom_cs), .rom_do(rom_do), .cfg_word(cfg_word), .irq(irq));
